// file: hw/wdt_down_counter.sv
// 24-bit watchdog down-counter with reload
`timescale 1ns/1ps
module wdt_down_counter
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Core carrier
  wdt_core_if.cnt core
);

  logic [23:0] count_r;  // Time-out counter

  // Reload wins over a tick; counter parks at zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count_r <= TC_RST;
    end else if (core.reload) begin
      count_r <= core.reload_val;
    end else if (core.run && core.tick && (count_r != 24'h000000)) begin
      count_r <= count_r - 24'h000001;
    end
  end

  assign core.count = count_r;

endmodule

// file: hw/wdt_tick_gen.sv
// Watchdog clock sampling, source selection and divide-by-four prescaler
`timescale 1ns/1ps
module wdt_tick_gen
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Oscillator inputs from other domains
  input wire logic irc_clk_in,
  input wire logic wdo_clk_in,
  // Core carrier
  wdt_core_if.tick_src core
);

  logic irc_s1_r, irc_s2_r, irc_s3_r;  // INTERNAL_RC_OSCILLATOR synchroniser and edge history
  logic wdo_s1_r, wdo_s2_r, wdo_s3_r;  // DEDICATED_WATCHDOG_OSCILLATOR synchroniser and edge history
  logic [1:0] presc_r;                 // Prescaler phase
  logic tick_r;                        // Registered tick
  logic edge_sel;                      // Rising edge of selected source

  // Two flops per oscillator, third flop only for edge detection
  always_ff @(posedge clk_in) begin
    irc_s1_r <= irc_clk_in;
    irc_s2_r <= irc_s1_r;
    irc_s3_r <= irc_s2_r;
    wdo_s1_r <= wdo_clk_in;
    wdo_s2_r <= wdo_s1_r;
    wdo_s3_r <= wdo_s2_r;
  end

  // Source select; the oscillators must stay below half the system clock
  always_comb begin
    case (core.sel)
      SRC_WDO: edge_sel = wdo_s2_r & ~wdo_s3_r;
      SRC_MAIN: edge_sel = 1'b1;
      default: edge_sel = irc_s2_r & ~irc_s3_r;
    endcase
  end

  // One tick per four watchdog clock periods
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !core.run) begin
      presc_r <= 2'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= edge_sel && (presc_r == PRESC_LAST);
      if (edge_sel) begin
        presc_r <= presc_r + 2'h1;
      end
    end
  end

  assign core.tick = tick_r;

endmodule

// file: hw/windowed_watchdog_timer.sv
// Windowed watchdog timer with AXI4-Lite register slave
//
// Behaviour
// - Expiry without reload resets the chip
// - Windowed mode: reload only between min and max
// - Optional warning interrupt at programmable count
// - Enable is set-only; cleared by reset or event
// - Bad or incomplete feed acts like time-out
// - Watchdog-reset flag survives the chip reset
// - 24-bit counter through internal prescaler
// - Period 256x4 up to 2^24x4 clocks
// - Windowed variant: INTERNAL_RC_OSCILLATOR or watchdog oscillator
// - Plain variant adds main clock source
// - Optionally keeps running in deep sleep
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module windowed_watchdog_timer
  import wdt_pkg::*;
#(
  parameter bit WINDOWED = 1'b1  // Windowed variant when set, plain otherwise
) (
  // Clock and resets
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic por_in,
  // AXI4-Lite write address
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  // AXI4-Lite write data
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  // AXI4-Lite write response
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // AXI4-Lite read address
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  // AXI4-Lite read data
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Watchdog clock sources
  input wire logic irc_clk_in,
  input wire logic wdo_clk_in,
  // Power state
  input wire logic deep_sleep_in,
  // Watchdog outputs
  output logic chip_reset_out,
  output logic wdt_irq_out,
  output logic warn_irq_out,
  output logic wake_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  wdt_core_if core ();  // Carrier to tick generator and counter

  // Bus slave state
  logic aw_ready_r, w_ready_r, b_valid_r, ar_ready_r, r_valid_r;
  logic aw_full_r, w_full_r;       // Address or data captured
  logic [7:0] aw_addr_r;           // Captured write address
  logic [31:0] w_data_r;           // Captured write data
  logic [3:0] w_strb_r;            // Captured write strobes
  logic [1:0] b_resp_r, r_resp_r;  // Response codes
  logic [31:0] r_data_r;           // Read data
  logic aw_hs, w_hs, ar_hs;        // Handshakes this cycle
  logic do_write;                  // Write performed this cycle
  logic aw_full_nxt, w_full_nxt, b_valid_nxt, r_valid_nxt;

  // Control fields
  logic en_r;         // Watchdog enabled
  logic rst_en_r;     // Event resets chip (else interrupt)
  logic win_en_r;     // Windowed feeding
  logic sleep_run_r;  // Keep running in deep sleep
  logic warn_en_r;    // Warning interrupt enabled
  logic [1:0] sel_r;  // Clock source select
  logic [23:0] tc_r, warn_r, window_r;

  // Status flags
  logic tout_flag_r, warn_flag_r, ferr_flag_r;

  // Sequencer and outputs
  wd_state_t state_r;
  logic [7:0] hold_r;  // Reset pulse cycles left
  logic chip_reset_r, wdt_irq_r, warn_irq_r, wake_r;
  logic armed_r;       // First feed key seen

  // Events
  logic running, good_feed, feed_err, win_err, expire, warn_hit, fault;
  logic [31:0] ctrl_img, stat_img, wr_word;
  logic [31:0] rd_word;
  logic rd_ok, wr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address belongs to the register map
  function automatic logic addr_known(input logic [7:0] a);
    return (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_TC) || (a == OFS_FEED)
        || (a == OFS_COUNT) || (a == OFS_WARN) || (a == OFS_WINDOW);
  endfunction

  // Time-out value never below the shortest legal period
  function automatic logic [23:0] clamp_tc(input logic [23:0] v);
    return (v < TC_MIN) ? TC_MIN : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign aw_hs = awvalid_in && aw_ready_r;
  assign w_hs = wvalid_in && w_ready_r;
  assign ar_hs = arvalid_in && ar_ready_r;
  assign do_write = aw_full_r && w_full_r && !b_valid_r;
  assign aw_full_nxt = (aw_full_r || aw_hs) && !do_write;
  assign w_full_nxt = (w_full_r || w_hs) && !do_write;
  assign b_valid_nxt = do_write || (b_valid_r && !bready_in);
  assign r_valid_nxt = ar_hs || (r_valid_r && !rready_in);
  assign wr_ok = addr_known(aw_addr_r);
  assign rd_ok = addr_known(araddr_in);
  assign wr_word = merge_strb(ctrl_img, w_data_r, w_strb_r);

  // Write channels: address and data are taken in either order
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_ready_r <= 1'b0;
      w_ready_r <= 1'b0;
      b_valid_r <= 1'b0;
      b_resp_r <= RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      // Ready drops while a word is held or the response waits
      aw_ready_r <= !aw_full_nxt && !b_valid_nxt;
      w_ready_r <= !w_full_nxt && !b_valid_nxt;
      b_valid_r <= b_valid_nxt;
      if (aw_hs) begin
        aw_addr_r <= awaddr_in;
      end
      if (w_hs) begin
        w_data_r <= wdata_in;
        w_strb_r <= wstrb_in;
      end
      if (do_write) begin
        b_resp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read data mux
  always_comb begin
    case (araddr_in)
      OFS_CTRL: rd_word = ctrl_img;
      OFS_STAT: rd_word = stat_img;
      OFS_TC: rd_word = {8'h00, tc_r};
      OFS_COUNT: rd_word = {8'h00, core.count};
      OFS_WARN: rd_word = {8'h00, warn_r};
      OFS_WINDOW: rd_word = {8'h00, window_r};
      default: rd_word = 32'h00000000;  // Feed and unmapped read as zero
    endcase
  end

  // Read channel: one read in flight, data registered
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ar_ready_r <= 1'b0;
      r_valid_r <= 1'b0;
      r_data_r <= 32'h00000000;
      r_resp_r <= RESP_OKAY;
    end else begin
      ar_ready_r <= !r_valid_nxt;
      r_valid_r <= r_valid_nxt;
      if (ar_hs) begin
        r_data_r <= rd_word;
        r_resp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register images

  assign ctrl_img = {25'h0000000, sel_r, warn_en_r, sleep_run_r, win_en_r, rst_en_r, en_r};
  assign stat_img = {29'h00000000, ferr_flag_r, warn_flag_r, tout_flag_r};

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Enable only ever set by software; hardware reset or an event clears it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      en_r <= 1'b0;
    end else if (fault || state_r == S_FIRE) begin
      en_r <= 1'b0;
    end else if (do_write && aw_addr_r == OFS_CTRL && wr_word[CTRL_EN_BIT]) begin
      en_r <= 1'b1;
    end
  end

  // Mode bits, freely writable
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rst_en_r <= 1'b0;
      win_en_r <= 1'b0;
      sleep_run_r <= 1'b0;
      warn_en_r <= 1'b0;
      sel_r <= SRC_IRC;
    end else if (do_write && aw_addr_r == OFS_CTRL) begin
      rst_en_r <= wr_word[CTRL_RST_BIT];
      win_en_r <= wr_word[CTRL_WIN_BIT] && WINDOWED;
      sleep_run_r <= wr_word[CTRL_SLEEP_BIT];
      warn_en_r <= wr_word[CTRL_WARN_BIT];
      // Main clock exists only in the plain variant
      if (WINDOWED && wr_word[CTRL_SEL_LSB +: 2] == SRC_MAIN) begin
        sel_r <= SRC_IRC;
      end else begin
        sel_r <= wr_word[CTRL_SEL_LSB +: 2];
      end
    end
  end

  // Time-out, warning and window values
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tc_r <= TC_RST;
      warn_r <= WARN_RST;
      window_r <= WINDOW_RST;
    end else if (do_write) begin
      case (aw_addr_r)
        OFS_TC: tc_r <= clamp_tc(24'(merge_strb({8'h00, tc_r}, w_data_r, w_strb_r)));
        OFS_WARN: warn_r <= 24'(merge_strb({8'h00, warn_r}, w_data_r, w_strb_r));
        OFS_WINDOW: window_r <= 24'(merge_strb({8'h00, window_r}, w_data_r, w_strb_r));
        default: begin
          // Other addresses leave the values alone
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feed sequence

  // Any write while armed must be the second key to the feed register
  always_comb begin
    good_feed = 1'b0;
    feed_err = 1'b0;
    if (do_write && running) begin
      if (armed_r) begin
        good_feed = (aw_addr_r == OFS_FEED) && w_strb_r[0]
                 && (w_data_r[7:0] == FEED_KEY2);
        feed_err = !good_feed;
      end else if (aw_addr_r == OFS_FEED) begin
        feed_err = !(w_strb_r[0] && (w_data_r[7:0] == FEED_KEY1));
      end
    end
  end

  // Arm on the first key, disarm on anything after it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !running) begin
      armed_r <= 1'b0;
    end else if (do_write) begin
      armed_r <= !armed_r && (aw_addr_r == OFS_FEED) && w_strb_r[0]
              && (w_data_r[7:0] == FEED_KEY1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter events

  assign running = (state_r == S_RUN);
  // Reload while the counter is above the window value is too early
  assign win_err = good_feed && win_en_r && (core.count > window_r);
  assign expire = running && core.tick && (core.count == 24'h000000);
  assign warn_hit = running && warn_en_r && core.tick && (core.count == warn_r);
  assign fault = running && (expire || feed_err || win_err);

  // Counter steering; held at the time-out value while idle
  assign core.reload = !running || (good_feed && !win_err);
  assign core.reload_val = tc_r;
  assign core.sel = (deep_sleep_in && sleep_run_r) ? SRC_WDO : sel_r;
  // Only the watchdog oscillator may run through deep sleep
  assign core.run = running && (!deep_sleep_in || sleep_run_r);

  wdt_tick_gen u_tick (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .irc_clk_in(irc_clk_in),
    .wdo_clk_in(wdo_clk_in),
    .core(core.tick_src)
  );

  wdt_down_counter u_count (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .core(core.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Reset pulse must outlive the system reset it causes, so only power-on cuts it short
  always_ff @(posedge clk_in) begin
    if (por_in) begin
      state_r <= S_OFF;
      hold_r <= 8'h00;
      chip_reset_r <= 1'b0;
    end else begin
      case (state_r)
        S_OFF: begin
          chip_reset_r <= 1'b0;
          if (en_r && !sys_rst_in) begin
            state_r <= S_RUN;
          end
        end
        S_RUN: begin
          if (sys_rst_in || !en_r) begin
            state_r <= S_OFF;
          end else if (fault && rst_en_r) begin
            state_r <= S_FIRE;
            hold_r <= 8'(RST_HOLD_CYC - 1);
            chip_reset_r <= 1'b1;
          end else if (fault) begin
            state_r <= S_OFF;  // Interrupt mode disables too
          end
        end
        S_FIRE: begin
          if (hold_r == 8'h00) begin
            state_r <= S_OFF;
            chip_reset_r <= 1'b0;
          end else begin
            hold_r <= hold_r - 8'h01;
          end
        end
        default: begin
          state_r <= S_OFF;
          chip_reset_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  // Event flag kept across system reset; a new event beats a clear
  always_ff @(posedge clk_in) begin
    if (por_in) begin
      tout_flag_r <= 1'b0;
      ferr_flag_r <= 1'b0;
    end else begin
      tout_flag_r <= (tout_flag_r && !(do_write && aw_addr_r == OFS_STAT
                      && w_strb_r[0] && w_data_r[STAT_TOUT_BIT])) || fault;
      ferr_flag_r <= (ferr_flag_r && !(do_write && aw_addr_r == OFS_STAT
                      && w_strb_r[0] && w_data_r[STAT_FERR_BIT]))
                     || (running && (feed_err || win_err));
    end
  end

  // Warning flag, cleared by hardware reset or write one
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      warn_flag_r <= 1'b0;
    end else begin
      warn_flag_r <= (warn_flag_r && !(do_write && aw_addr_r == OFS_STAT
                      && w_strb_r[0] && w_data_r[STAT_WARN_BIT])) || warn_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage

  // Interrupt lines follow the flags one cycle later
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wdt_irq_r <= 1'b0;
      warn_irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      wdt_irq_r <= tout_flag_r && !rst_en_r;
      warn_irq_r <= warn_flag_r && warn_en_r;
      wake_r <= deep_sleep_in && (warn_hit || fault);
    end
  end

  assign awready_out = aw_ready_r;
  assign wready_out = w_ready_r;
  assign bvalid_out = b_valid_r;
  assign bresp_out = b_resp_r;
  assign arready_out = ar_ready_r;
  assign rvalid_out = r_valid_r;
  assign rdata_out = r_data_r;
  assign rresp_out = r_resp_r;
  assign chip_reset_out = chip_reset_r;
  assign wdt_irq_out = wdt_irq_r;
  assign warn_irq_out = warn_irq_r;
  assign wake_out = wake_r;

endmodule

// file: inc/wdt_core_if.sv
// Carrier between the watchdog control, its tick generator and its counter
`timescale 1ns/1ps
interface wdt_core_if;
  import wdt_pkg::*;
  logic [1:0] sel;          // Selected watchdog clock source
  logic run;                // Counting allowed
  logic tick;               // One prescaled watchdog period, one cycle
  logic reload;             // Load counter from reload_val
  logic [23:0] reload_val;  // Programmed time-out value
  logic [23:0] count;       // Current counter value

  modport tick_src (input sel, input run, output tick);
  modport cnt (input tick, input run, input reload, input reload_val, output count);
  modport ctl (output sel, output run, output reload, output reload_val,
               input tick, input count);
endinterface

// file: inc/wdt_pkg.sv
// Shared constants, types and helpers of the windowed watchdog timer
package wdt_pkg;

  // Bus and counter widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 24;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_TC = 8'h08;
  localparam logic [7:0] OFS_FEED = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_WARN = 8'h14;
  localparam logic [7:0] OFS_WINDOW = 8'h18;

  // Control register fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_RST_BIT = 1;
  localparam int unsigned CTRL_WIN_BIT = 2;
  localparam int unsigned CTRL_SLEEP_BIT = 3;
  localparam int unsigned CTRL_WARN_BIT = 4;
  localparam int unsigned CTRL_SEL_LSB = 5;

  // Status register fields (write one to clear)
  localparam int unsigned STAT_TOUT_BIT = 0;
  localparam int unsigned STAT_WARN_BIT = 1;
  localparam int unsigned STAT_FERR_BIT = 2;

  // Reset values and limits
  localparam logic [23:0] TC_MIN = 24'h0000FF;
  localparam logic [23:0] TC_RST = 24'h0000FF;
  localparam logic [23:0] WARN_RST = 24'h000000;
  localparam logic [23:0] WINDOW_RST = 24'hFFFFFF;

  // Feed keys, written one after the other
  localparam logic [7:0] FEED_KEY1 = 8'hAA;
  localparam logic [7:0] FEED_KEY2 = 8'h55;

  // Fixed divide-by-four prescaler, terminal count
  localparam logic [1:0] PRESC_LAST = 2'h3;

  // Chip reset pulse length
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned RST_HOLD_NS = 100;
  localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Watchdog clock sources
  typedef enum logic [1:0] {
    SRC_IRC = 2'h0,
    SRC_WDO = 2'h1,
    SRC_MAIN = 2'h2
  } src_t;

  // Watchdog sequencer states
  typedef enum logic [2:0] {
    S_OFF = 3'b001,
    S_RUN = 3'b010,
    S_FIRE = 3'b100
  } wd_state_t;

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// file: tb/wdt_props.sv
// Port-level bus and watchdog output checks for the windowed watchdog timer
`timescale 1ns/1ps
module wdt_props
  import wdt_pkg::*;
(
  // Clock, resets and power state
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic por_in,
  input wire logic deep_sleep_in,
  // Register bus
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic [1:0] bresp_out,
  input wire logic bvalid_out,
  input wire logic bready_in,
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic [31:0] rdata_out,
  input wire logic [1:0] rresp_out,
  input wire logic rvalid_out,
  input wire logic rready_in,
  // Watchdog outputs
  input wire logic chip_reset_out,
  input wire logic wdt_irq_out,
  input wire logic warn_irq_out,
  input wire logic wake_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // High cycles of the chip reset pulse; only power-on reset may cut it short
  logic [5:0] hi_r;
  always_ff @(posedge clk_in) begin
    if (por_in || !chip_reset_out) begin
      hi_r <= 6'h00;
    end else begin
      hi_r <= hi_r + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Sys reset does not end the pulse, so only power-on reset disables this one
  property p_pulse;
    disable iff (por_in) $fell(chip_reset_out) |-> hi_r == 6'(RST_HOLD_CYC);
  endproperty
  a_pulse: assert property (p_pulse) else $error("chip reset pulse length wrong");
  property p_bwait;
    awvalid_in && awready_out && wvalid_in && wready_out |-> ##1 !bvalid_out ##1 bvalid_out;
  endproperty
  a_bwait: assert property (p_bwait) else $error("write response latency wrong");
  property p_rwait;
    arvalid_in && arready_out |=> rvalid_out;
  endproperty
  a_rwait: assert property (p_rwait) else $error("read data latency wrong");
  property p_bhold;
    bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out) && $stable(rresp_out);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_refuse;
    (bvalid_out |-> !awready_out && !wready_out) and (rvalid_out |-> !arready_out);
  endproperty
  a_refuse: assert property (p_refuse) else $error("ready while answer pending");
  property p_rst;
    disable iff (por_in) sys_rst_in |=> !(awready_out || arready_out || bvalid_out ||
      rvalid_out || wdt_irq_out);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active during reset");
  property p_rderr;
    arvalid_in && arready_out && araddr_in > OFS_WINDOW |=>
      rresp_out == RESP_SLVERR && rdata_out == 32'h0000_0000;
  endproperty
  a_rderr: assert property (p_rderr) else $error("unmapped read not refused");
  property p_irqx;
    $rose(chip_reset_out) |-> !wdt_irq_out;
  endproperty
  a_irqx: assert property (p_irqx) else $error("reset and interrupt together");
  property p_wake;
    $rose(wdt_irq_out) && deep_sleep_in && !$past(sys_rst_in, 2) |-> $past(wake_out);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake in deep sleep");

  // Main scenarios reached
  c_chip: cover property ($rose(chip_reset_out));
  c_irq: cover property ($rose(wdt_irq_out));
  c_warn: cover property ($rose(warn_irq_out));
endmodule

bind windowed_watchdog_timer wdt_props chk_u (.*);

// file: tb/windowed_watchdog_timer_tb.sv
// Self-checking bench of the windowed watchdog timer
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %0t got %0h exp %0h", $time, a, e); end end
// Bounded wait over at least one edge; a hang ends the run
`define WAITF(c) begin waited = 0; do begin @(posedge clk_in); waited++; end \
  while (!(c) && waited < 20000); if (!(c)) begin n_errors++; \
  $display("BAD %0t timeout", $time); end_sim(); end end
module windowed_watchdog_timer_tb;
  import wdt_pkg::*;
  logic clk_in, sys_rst_in, por_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
  logic irc_clk_in, wdo_clk_in, deep_sleep_in, awready_out, wready_out, bvalid_out;
  logic arready_out, rvalid_out, chip_reset_out, wdt_irq_out, warn_irq_out, wake_out;
  logic [7:0] awaddr_in, araddr_in;
  logic [31:0] wdata_in, rdata_out, rd_d;
  logic [3:0] wstrb_in;
  logic [1:0] bresp_out, rresp_out, rd_r;
  int n_errors, check_count, waited;

  windowed_watchdog_timer #(.WINDOWED(1'b1)) dut_u (.*);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // 200 MHz system clock; oscillators unrelated in phase and well below half of it
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    irc_clk_in = 1'b0;
    forever #20 irc_clk_in = ~irc_clk_in;
  end
  initial begin
    wdo_clk_in = 1'b0;
    forever #27 wdo_clk_in = ~wdo_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Write: both channels offered together, each dropped once taken; ready raised late
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    awaddr_in <= a;
    wdata_in <= d;
    wstrb_in <= s;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    waited = 0;
    do begin
      @(posedge clk_in);
      waited++;
      if (awready_out) awvalid_in <= 1'b0;
      if (wready_out) wvalid_in <= 1'b0;
    end while ((awvalid_in || wvalid_in) && waited < 100);
    `WAITF(bvalid_out)
    bready_in <= 1'b1;
    @(posedge clk_in);
    rd_r = bresp_out;
    bready_in <= 1'b0;
  endtask

  // Read: result lands in rd_d and rd_r
  task automatic rd(input logic [7:0] a);
    araddr_in <= a;
    arvalid_in <= 1'b1;
    `WAITF(arready_out)
    arvalid_in <= 1'b0;
    `WAITF(rvalid_out)
    rready_in <= 1'b1;
    @(posedge clk_in);
    rd_d = rdata_out;
    rd_r = rresp_out;
    rready_in <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped place, clamp of short periods, clock source field
  task automatic s_regs();
    rd(OFS_TC);
    `CHK(rd_d[23:0], TC_RST)
    rd(OFS_WINDOW);
    `CHK(rd_d[23:0], WINDOW_RST)
    rd(8'h1C);
    `CHK({rd_r, rd_d}, {RESP_SLVERR, 32'h0000_0000})
    wr(OFS_TC, 32'h0000_0010);
    rd(OFS_TC);
    `CHK(rd_d[23:0], TC_MIN)
    wr(OFS_CTRL, 32'h0000_0020);
    rd(OFS_CTRL);
    `CHK(rd_d[6:5], SRC_WDO)
    wr(OFS_CTRL, 32'h0000_0040);
    rd(OFS_CTRL);
    `CHK(rd_d[6:5], SRC_IRC)
  endtask

  // Sticky enable, counting, good feed reload, then a wrong second key
  task automatic s_feed();
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0000);
    rd(OFS_CTRL);
    `CHK(rd_d[0], 1'b1)
    repeat (300) @(posedge clk_in);
    rd(OFS_COUNT);
    `CHK(rd_d[23:0] > 24'hF2 && rd_d[23:0] < 24'hF9, 1'b1)
    wr(OFS_FEED, 32'h0000_00AA);
    wr(OFS_FEED, 32'h0000_0055);
    rd(OFS_COUNT);
    `CHK(rd_d[23:0] > 24'hFC, 1'b1)
    `CHK(wdt_irq_out, 1'b0)
    wr(OFS_FEED, 32'h0000_00AA);
    wr(OFS_FEED, 32'h0000_0012);
    `WAITF(wdt_irq_out)
    rd(OFS_STAT);
    `CHK(rd_d[2:0], 3'b101)
    rd(OFS_CTRL);
    `CHK(rd_d[0], 1'b0)
    wr(OFS_STAT, 32'h0000_0007);
    rd(OFS_STAT);
    `CHK({wdt_irq_out, rd_d[2:0]}, 4'h0)
  endtask

  // Warning and expiry timing, flag kept over sys reset, cleared by power-on
  task automatic s_tout();
    wr(OFS_WARN, 32'h00AB_CD80, 4'h1);
    rd(OFS_WARN);
    `CHK(rd_d[23:0], 24'h000080)
    wr(OFS_CTRL, 32'h0000_0013);
    `WAITF(warn_irq_out)
    `CHK(waited > 3990 && waited < 4200, 1'b1)
    `WAITF(chip_reset_out)
    `CHK(waited > 3990 && waited < 4200, 1'b1)
    `WAITF(!chip_reset_out)
    sys_rst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(OFS_STAT);
    `CHK(rd_d[0], 1'b1)
    por_in <= 1'b1;
    sys_rst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    por_in <= 1'b0;
    sys_rst_in <= 1'b0;
    rd(OFS_STAT);
    `CHK(rd_d[0], 1'b0)
  endtask

  // Feeding too early in windowed mode is a fault
  task automatic s_win();
    wr(OFS_WINDOW, 32'h0000_0010);
    deep_sleep_in <= 1'b1;
    wr(OFS_CTRL, 32'h0000_000D);
    repeat (2) begin
      wr(OFS_FEED, 32'h0000_00AA);
      wr(OFS_FEED, 32'h0000_0055);
    end
    `WAITF(wdt_irq_out)
    rd(OFS_STAT);
    `CHK(rd_d[2], 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Power-up: both resets for 8 cycles, then the scenarios in turn
  initial begin
    {sys_rst_in, por_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 7'h60;
    {awaddr_in, araddr_in, wdata_in, wstrb_in} = 52'h0;
    deep_sleep_in = 1'b0;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    por_in <= 1'b0;
    s_regs();
    s_feed();
    s_tout();
    s_win();
    end_sim();
  end
endmodule
